// *** serializer_core_config_pkg.sv ***
// Constants and types for the serializer base configuration registers
// Function
// - Address field reads the address in use; strapped and read-only without bypass
// - With bypass bit 0 set, address field is writable and the bus answers there
// - Writing 1 to reset bit 2 pulses a ROM reload; bit clears itself
// - Writing 1 to reset bit 1 resets logic and all writable registers; straps and settled flag kept; self-clearing
// - Writing 1 to reset bit 0 resets logic, keeps registers; self-clearing
// - Config bit 6 picks clock lane: 0 non-continuous, 1 continuous; resets 0
// - Config bits 5:4 pick data lanes: 00 one, 01 two, 11 four; reset 3
// - Config bit 1 enables transmit CRC generator; resets enabled
// - Config bit 0 takes bus voltage from index strap at start-up; writable
// - Mode field read-only strapped unless bypass bit 4 set, then writable
// - Strapped mode latched into mode field on power-down pin rising edge
// - Read-only bit 3 of mode register shows mode settled and latched
// - Mode codes: 000 sync, 010 ext clock, 011 internal clock, 101 parallel
// - Strap fields take reset values from strap pins at start-up
package serializer_core_config_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] OFS_BUS_ADDRESS_SELECT = 8'h00;
   localparam logic [7:0] OFS_RESET_CONTROL = 8'h01;
   localparam logic [7:0] OFS_GENERAL_CONFIGURATION = 8'h02;
   localparam logic [7:0] OFS_FORWARD_CHANNEL_MODE_SELECT = 8'h03;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int ADDR_BYPASS_BIT = 0;
   localparam int ROM_RELOAD_BIT = 2;
   localparam int FULL_RESET_BIT = 1;
   localparam int LOGIC_RESET_BIT = 0;
   localparam int MODE_BYPASS_BIT = 4;
   localparam int MODE_SETTLED_BIT = 3;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [1:0] LANES_RESET = 2'h3;
   localparam logic CLOCK_ON_RESET = 1'h0;
   localparam logic CRC_RESET = 1'h1;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [3:0] BIT_COUNT_FULL = 4'h8;
   // ----------------------------------------
   // Mode codes
   // ----------------------------------------
   localparam logic [2:0] MODE_SYNC = 3'h0;
   localparam logic [2:0] MODE_RESERVED = 3'h1;
   localparam logic [2:0] MODE_NONSYNC_EXT = 3'h2;
   localparam logic [2:0] MODE_NONSYNC_INT = 3'h3;
   localparam logic [2:0] MODE_PARALLEL = 3'h5;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef struct packed {
      logic reserved_7;
      logic clock_lane_always_on;
      logic [1:0] data_lanes;
      logic [1:0] reserved_3_2;
      logic crc_tx_enable;
      logic bus_voltage_1v8;
   } gen_cfg_t;
   typedef struct packed {
      logic [6:0] bus_address;
      logic [2:0] mode;
      logic index_level;
   } strap_t;
   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_INDEX, ST_ACK_INDEX,
      ST_WDATA, ST_ACK_WDATA, ST_RDATA, ST_ACK_RDATA
   } i2c_state_t;
endpackage : serializer_core_config_pkg

// *** serializer_core_config_regs.sv ***
// Base configuration registers with their I2C target
`timescale 1ns/1ps
module serializer_core_config_regs (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_power_down_pin,
   input wire logic [6:0] i_address_strap,
   input wire logic [2:0] i_mode_strap,
   input wire logic i_index_strap_pin,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_out,
   output logic o_sda_oe,
   output logic [6:0] o_bus_address,
   output logic o_rom_reload_trigger,
   output logic o_logic_reset,
   output logic o_clock_lane_always_on,
   output logic [1:0] o_data_lanes,
   output logic o_crc_tx_enable,
   output logic o_bus_voltage_1v8,
   output logic [2:0] o_mode,
   output logic o_mode_settled
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic pdb_prev_r;
   logic strap_load;
   logic full_reset_r;
   logic reg_rst;
   serializer_core_config_pkg::strap_t strap_r;
   logic address_strap_bypass_r;
   logic [6:0] bus_address_field_r;
   logic [4:0] reset_reserved_r;
   logic rom_reload_r;
   logic logic_reset_r;
   serializer_core_config_pkg::gen_cfg_t gen_cfg_r;
   logic mode_reserved_7_r;
   logic mode_reserved_5_r;
   logic mode_strap_bypass_r;
   logic [2:0] mode_field_r;
   logic mode_settled_r;
   logic [6:0] addr_in_use;
   logic [2:0] mode_in_use;
   serializer_core_config_pkg::i2c_state_t state_r;
   logic scl_q_r;
   logic sda_q_r;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic [7:0] shift_r;
   logic [7:0] tx_r;
   logic [3:0] cnt_r;
   logic [7:0] index_r;
   logic read_dir_r;
   logic wr_en;
   logic [7:0] wr_data;
   logic sda_oe_r;
   logic [7:0] rd_now;

   // ----------------------------------------
   // Register read decode
   // ----------------------------------------
   function automatic logic [7:0] read_reg(input logic [7:0] idx);
      logic [7:0] v;
      v = serializer_core_config_pkg::BYTE_ZERO;
      if (idx == serializer_core_config_pkg::OFS_BUS_ADDRESS_SELECT) begin
         v = {addr_in_use, address_strap_bypass_r};
      end else if (idx == serializer_core_config_pkg::OFS_RESET_CONTROL) begin
         v = {reset_reserved_r, rom_reload_r, full_reset_r, logic_reset_r};
      end else if (idx == serializer_core_config_pkg::OFS_GENERAL_CONFIGURATION) begin
         v = gen_cfg_r;
      end else if (idx == serializer_core_config_pkg::OFS_FORWARD_CHANNEL_MODE_SELECT) begin
         v = {mode_reserved_7_r, strap_r.index_level, mode_reserved_5_r,
              mode_strap_bypass_r, mode_settled_r, mode_in_use};
      end
      return v;
   endfunction : read_reg
   assign rd_now = read_reg(index_r);

   // ----------------------------------------
   // Strap capture and resets
   // ----------------------------------------
   assign strap_load = i_power_down_pin & ~pdb_prev_r;
   assign reg_rst = i_sys_rst | ~i_power_down_pin | full_reset_r;

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         pdb_prev_r <= 1'b0;
      end else begin
         pdb_prev_r <= i_power_down_pin;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         strap_r <= '0;
      end else if (strap_load) begin
         strap_r <= {i_address_strap, i_mode_strap, i_index_strap_pin};
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst || !i_power_down_pin) begin
         mode_settled_r <= 1'b0;
      end else if (pdb_prev_r) begin
         mode_settled_r <= 1'b1;
      end
   end

   // ----------------------------------------
   // Address register
   // ----------------------------------------
   // Strapped unless bypassed
   assign addr_in_use = address_strap_bypass_r ? bus_address_field_r : strap_r.bus_address;
   assign mode_in_use = mode_strap_bypass_r ? mode_field_r : strap_r.mode;

   always_ff @(posedge i_mclk) begin
      if (reg_rst) begin
         address_strap_bypass_r <= 1'b0;
         bus_address_field_r <= '0;
      end else if (wr_en && index_r == serializer_core_config_pkg::OFS_BUS_ADDRESS_SELECT) begin
         address_strap_bypass_r <= wr_data[serializer_core_config_pkg::ADDR_BYPASS_BIT];
         if (wr_data[serializer_core_config_pkg::ADDR_BYPASS_BIT]) begin
            bus_address_field_r <= wr_data[7:1];
         end else begin
            bus_address_field_r <= strap_r.bus_address;
         end
      end
   end

   // ----------------------------------------
   // Reset control register
   // ----------------------------------------
   always_ff @(posedge i_mclk) begin
      if (reg_rst) begin
         reset_reserved_r <= '0;
         rom_reload_r <= 1'b0;
         logic_reset_r <= 1'b0;
      end else if (wr_en && index_r == serializer_core_config_pkg::OFS_RESET_CONTROL) begin
         reset_reserved_r <= wr_data[7:3];
         rom_reload_r <= wr_data[serializer_core_config_pkg::ROM_RELOAD_BIT];
         logic_reset_r <= wr_data[serializer_core_config_pkg::LOGIC_RESET_BIT];
      end else begin
         rom_reload_r <= 1'b0;
         logic_reset_r <= 1'b0;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst || full_reset_r) begin
         full_reset_r <= 1'b0;
      end else if (wr_en && index_r == serializer_core_config_pkg::OFS_RESET_CONTROL) begin
         full_reset_r <= wr_data[serializer_core_config_pkg::FULL_RESET_BIT];
      end
   end

   // ----------------------------------------
   // General configuration register
   // ----------------------------------------
   always_ff @(posedge i_mclk) begin
      if (reg_rst) begin
         gen_cfg_r <= '0;
         gen_cfg_r.clock_lane_always_on <= serializer_core_config_pkg::CLOCK_ON_RESET;
         gen_cfg_r.data_lanes <= serializer_core_config_pkg::LANES_RESET;
         gen_cfg_r.crc_tx_enable <= serializer_core_config_pkg::CRC_RESET;
         gen_cfg_r.bus_voltage_1v8 <= strap_r.index_level;
      end else if (strap_load) begin
         gen_cfg_r.bus_voltage_1v8 <= i_index_strap_pin;
      end else if (wr_en && index_r == serializer_core_config_pkg::OFS_GENERAL_CONFIGURATION) begin
         gen_cfg_r <= wr_data;
      end
   end

   // ----------------------------------------
   // Mode select register
   // ----------------------------------------
   always_ff @(posedge i_mclk) begin
      if (reg_rst) begin
         mode_reserved_7_r <= 1'b0;
         mode_reserved_5_r <= 1'b0;
         mode_strap_bypass_r <= 1'b0;
         mode_field_r <= serializer_core_config_pkg::MODE_SYNC;
      end else if (wr_en &&
                   index_r == serializer_core_config_pkg::OFS_FORWARD_CHANNEL_MODE_SELECT) begin
         mode_reserved_7_r <= wr_data[7];
         mode_reserved_5_r <= wr_data[5];
         mode_strap_bypass_r <= wr_data[serializer_core_config_pkg::MODE_BYPASS_BIT];
         if (wr_data[serializer_core_config_pkg::MODE_BYPASS_BIT]) begin
            mode_field_r <= wr_data[2:0];
         end else begin
            mode_field_r <= strap_r.mode;
         end
      end
   end

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_bus_address <= '0;
         o_clock_lane_always_on <= serializer_core_config_pkg::CLOCK_ON_RESET;
         o_data_lanes <= serializer_core_config_pkg::LANES_RESET;
         o_crc_tx_enable <= serializer_core_config_pkg::CRC_RESET;
         o_bus_voltage_1v8 <= 1'b0;
         o_mode <= serializer_core_config_pkg::MODE_SYNC;
         o_mode_settled <= 1'b0;
         o_rom_reload_trigger <= 1'b0;
         o_logic_reset <= 1'b0;
         o_sda_out <= 1'b0;
      end else begin
         o_bus_address <= addr_in_use;
         o_clock_lane_always_on <= gen_cfg_r.clock_lane_always_on;
         o_data_lanes <= gen_cfg_r.data_lanes;
         o_crc_tx_enable <= gen_cfg_r.crc_tx_enable;
         o_bus_voltage_1v8 <= gen_cfg_r.bus_voltage_1v8;
         // Mode code passed to forward channel
         o_mode <= mode_in_use;
         o_mode_settled <= mode_settled_r;
         o_rom_reload_trigger <= rom_reload_r;
         o_logic_reset <= logic_reset_r | full_reset_r;
         o_sda_out <= 1'b0;
      end
   end
   assign o_sda_oe = sda_oe_r;

   // ----------------------------------------
   // I2C bus conditions
   // ----------------------------------------
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
      end else begin
         scl_q_r <= i_scl;
         sda_q_r <= i_sda;
      end
   end
   assign scl_rise = i_scl & ~scl_q_r;
   assign scl_fall = ~i_scl & scl_q_r;
   assign start_det = i_scl & scl_q_r & sda_q_r & ~i_sda;
   assign stop_det = i_scl & scl_q_r & ~sda_q_r & i_sda;
   assign wr_en = (state_r == serializer_core_config_pkg::ST_WDATA) && scl_fall &&
                  (cnt_r == serializer_core_config_pkg::BIT_COUNT_FULL);
   assign wr_data = shift_r;

   // ----------------------------------------
   // I2C target state machine
   // ----------------------------------------
   always_ff @(posedge i_mclk) begin
      if (reg_rst) begin
         state_r <= serializer_core_config_pkg::ST_IDLE;
         shift_r <= '0;
         tx_r <= '0;
         cnt_r <= '0;
         index_r <= '0;
         read_dir_r <= 1'b0;
         sda_oe_r <= 1'b0;
      end else if (start_det) begin
         state_r <= serializer_core_config_pkg::ST_ADDR;
         cnt_r <= '0;
         sda_oe_r <= 1'b0;
      end else if (stop_det) begin
         state_r <= serializer_core_config_pkg::ST_IDLE;
         sda_oe_r <= 1'b0;
      end else if (scl_rise) begin
         case (state_r)
            serializer_core_config_pkg::ST_ADDR,
            serializer_core_config_pkg::ST_INDEX,
            serializer_core_config_pkg::ST_WDATA: begin
               shift_r <= {shift_r[6:0], i_sda};
               cnt_r <= cnt_r + 4'h1;
            end
            serializer_core_config_pkg::ST_RDATA: begin
               cnt_r <= cnt_r + 4'h1;
            end
            serializer_core_config_pkg::ST_ACK_RDATA: begin
               if (i_sda) begin
                  state_r <= serializer_core_config_pkg::ST_IDLE;
               end
            end
            default: begin
            end
         endcase
      end else if (scl_fall) begin
         case (state_r)
            serializer_core_config_pkg::ST_ADDR: begin
               if (cnt_r == serializer_core_config_pkg::BIT_COUNT_FULL) begin
                  if (shift_r[7:1] == addr_in_use) begin
                     state_r <= serializer_core_config_pkg::ST_ACK_ADDR;
                     read_dir_r <= shift_r[0];
                     sda_oe_r <= 1'b1;
                  end else begin
                     state_r <= serializer_core_config_pkg::ST_IDLE;
                  end
               end
            end
            serializer_core_config_pkg::ST_ACK_ADDR: begin
               cnt_r <= '0;
               if (read_dir_r) begin
                  state_r <= serializer_core_config_pkg::ST_RDATA;
                  tx_r <= rd_now;
                  sda_oe_r <= ~rd_now[7];
               end else begin
                  state_r <= serializer_core_config_pkg::ST_INDEX;
                  sda_oe_r <= 1'b0;
               end
            end
            serializer_core_config_pkg::ST_INDEX: begin
               if (cnt_r == serializer_core_config_pkg::BIT_COUNT_FULL) begin
                  state_r <= serializer_core_config_pkg::ST_ACK_INDEX;
                  index_r <= shift_r;
                  sda_oe_r <= 1'b1;
               end
            end
            serializer_core_config_pkg::ST_WDATA: begin
               if (cnt_r == serializer_core_config_pkg::BIT_COUNT_FULL) begin
                  state_r <= serializer_core_config_pkg::ST_ACK_WDATA;
                  sda_oe_r <= 1'b1;
               end
            end
            serializer_core_config_pkg::ST_ACK_INDEX: begin
               state_r <= serializer_core_config_pkg::ST_WDATA;
               cnt_r <= '0;
               sda_oe_r <= 1'b0;
            end
            serializer_core_config_pkg::ST_ACK_WDATA: begin
               state_r <= serializer_core_config_pkg::ST_WDATA;
               index_r <= index_r + 8'h01;
               cnt_r <= '0;
               sda_oe_r <= 1'b0;
            end
            serializer_core_config_pkg::ST_RDATA: begin
               if (cnt_r == serializer_core_config_pkg::BIT_COUNT_FULL) begin
                  state_r <= serializer_core_config_pkg::ST_ACK_RDATA;
                  index_r <= index_r + 8'h01;
                  sda_oe_r <= 1'b0;
               end else begin
                  tx_r <= {tx_r[6:0], 1'b0};
                  sda_oe_r <= ~tx_r[6];
               end
            end
            serializer_core_config_pkg::ST_ACK_RDATA: begin
               state_r <= serializer_core_config_pkg::ST_RDATA;
               cnt_r <= '0;
               tx_r <= rd_now;
               sda_oe_r <= ~rd_now[7];
            end
            default: begin
            end
         endcase
      end
   end
endmodule : serializer_core_config_regs

// *** serializer_core_config_checker_asserts.sv ***
// Port checks for the configuration registers
`timescale 1ns/1ps
module serializer_core_config_checker (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_power_down_pin,
   input wire logic [6:0] i_address_strap,
   input wire logic [2:0] i_mode_strap,
   input wire logic i_scl,
   input wire logic o_sda_oe,
   input wire logic [6:0] o_bus_address,
   input wire logic o_rom_reload_trigger,
   input wire logic o_logic_reset,
   input wire logic o_clock_lane_always_on,
   input wire logic [1:0] o_data_lanes,
   input wire logic o_crc_tx_enable,
   input wire logic [2:0] o_mode,
   input wire logic o_mode_settled
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_sys_rst);
   a_addr_from_strap: assert property ($rose(i_power_down_pin) |-> ##[1:4] o_bus_address == i_address_strap)
      else $error("address not loaded from strap");
   a_mode_latch: assert property ($rose(i_power_down_pin) |-> ##[1:4] o_mode == i_mode_strap)
      else $error("mode not latched from strap");
   a_settled_low: assert property ((!i_power_down_pin)[*3] |-> !o_mode_settled)
      else $error("settled flag high in power down");
   a_settled_rise: assert property ($rose(i_power_down_pin) |-> ##[1:4] o_mode_settled)
      else $error("settled flag late");
   a_reload_pulse: assert property (o_rom_reload_trigger |=> !o_rom_reload_trigger)
      else $error("reload trigger not self clearing");
   a_logic_pulse: assert property (o_logic_reset ##1 o_logic_reset |=> !o_logic_reset)
      else $error("logic reset not self clearing");
   a_cfg_hold: assert property (i_scl && $past(i_scl) && $past(i_power_down_pin) |->
      $stable({o_clock_lane_always_on, o_data_lanes, o_crc_tx_enable}))
      else $error("config changed outside a write");
   a_ack_timing: assert property ($rose(o_sda_oe) |-> $past(i_scl, 2) && !$past(i_scl))
      else $error("data line driven at wrong moment");
   a_oe_scl_high: assert property (i_scl && $past(i_scl) |-> $stable(o_sda_oe))
      else $error("data line changed with clock high");
endmodule : serializer_core_config_checker
bind serializer_core_config_regs serializer_core_config_checker i_chk (
   .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_power_down_pin(i_power_down_pin),
   .i_address_strap(i_address_strap), .i_mode_strap(i_mode_strap), .i_scl(i_scl),
   .o_sda_oe(o_sda_oe), .o_bus_address(o_bus_address),
   .o_rom_reload_trigger(o_rom_reload_trigger), .o_logic_reset(o_logic_reset),
   .o_clock_lane_always_on(o_clock_lane_always_on), .o_data_lanes(o_data_lanes),
   .o_crc_tx_enable(o_crc_tx_enable), .o_mode(o_mode), .o_mode_settled(o_mode_settled)
);

// *** i2c_host_model.sv ***
// Behavioural remote host on the two-wire register bus
`timescale 1ns/1ps
module i2c_host_model (
   input wire logic i_mclk,
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_low,
   output logic [7:0] o_rd_byte,
   output logic o_rd_valid
);
   int half = 4;
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
      o_rd_byte = 8'h00;
      o_rd_valid = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_mclk);
   endtask : tick
   task automatic bit_io(input logic b, output logic s);
      o_sda_low <= !b;
      tick(half);
      o_scl <= 1'b1;
      tick(half / 2);
      s = i_sda;
      tick(half / 2);
      o_scl <= 1'b0;
      tick(2);
   endtask : bit_io
   task automatic byte_io(input logic [7:0] d, input logic last, output logic [7:0] r);
      logic a;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r[i]);
      end
      bit_io(last, a);
   endtask : byte_io
   task automatic start_cond();
      o_sda_low <= 1'b0;
      tick(2);
      o_scl <= 1'b1;
      tick(half);
      o_sda_low <= 1'b1;
      tick(half);
      o_scl <= 1'b0;
      tick(2);
   endtask : start_cond
   task automatic stop_cond();
      o_sda_low <= 1'b1;
      tick(2);
      o_scl <= 1'b1;
      tick(half);
      o_sda_low <= 1'b0;
      tick(half);
   endtask : stop_cond
   task automatic write_reg(input logic [6:0] a, input logic [7:0] x, input logic [7:0] d);
      logic [7:0] r;
      start_cond();
      byte_io({a, 1'b0}, 1'b1, r);
      byte_io(x, 1'b1, r);
      byte_io(d, 1'b1, r);
      stop_cond();
   endtask : write_reg
   task automatic read_reg(input logic [6:0] a, input logic [7:0] x);
      logic [7:0] r;
      start_cond();
      byte_io({a, 1'b0}, 1'b1, r);
      byte_io(x, 1'b1, r);
      start_cond();
      byte_io({a, 1'b1}, 1'b1, r);
      byte_io(8'hFF, 1'b1, r);
      stop_cond();
      o_rd_byte <= r;
      o_rd_valid <= 1'b1;
      tick(1);
      o_rd_valid <= 1'b0;
   endtask : read_reg
endmodule : i2c_host_model

// *** serializer_core_config_regs_tb_top.sv ***
// Self-checking bench for the configuration registers
`timescale 1ns/1ps
module serializer_core_config_regs_tb_top;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic pd_pin = 1'b0;
   logic [6:0] addr_strap = 7'h40;
   logic [2:0] mode_strap = 3'h3;
   logic idx_strap = 1'b1;
   logic scl, sda_low, sda_out, sda_oe, rom_p, log_p, clk_on, crc_en, v18, settled, rd_valid;
   logic [6:0] bus_addr, sa, na;
   logic [1:0] lanes;
   logic [2:0] mode;
   logic [7:0] rd_byte, cfg;
   logic [31:0] seed = 32'h193B;
   logic [7:0] exp_q[$];
   logic [2:0] modes[5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5};
   int failures = 0;
   int n_checks = 0;
   int cyc = 0;
   int rom_n = 0;
   int log_n = 0;
   wire sda = !(sda_low | sda_oe);
   always #4 mclk = ~mclk;
   serializer_core_config_regs i_serializer_core_config_regs (
      .i_mclk(mclk), .i_sys_rst(sys_rst), .i_power_down_pin(pd_pin),
      .i_address_strap(addr_strap), .i_mode_strap(mode_strap), .i_index_strap_pin(idx_strap),
      .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
      .o_bus_address(bus_addr), .o_rom_reload_trigger(rom_p), .o_logic_reset(log_p),
      .o_clock_lane_always_on(clk_on), .o_data_lanes(lanes), .o_crc_tx_enable(crc_en),
      .o_bus_voltage_1v8(v18), .o_mode(mode), .o_mode_settled(settled));
   i2c_host_model i_i2c_host_model (.i_mclk(mclk), .i_sda(sda), .o_scl(scl),
      .o_sda_low(sda_low), .o_rd_byte(rd_byte), .o_rd_valid(rd_valid));
   function automatic logic [31:0] xs(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction : xs
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic finish_test();
      if (failures == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test
   task automatic rd(input logic [6:0] a, input logic [7:0] x, input logic [7:0] e);
      exp_q.push_back(e);
      i_i2c_host_model.read_reg(a, x);
   endtask : rd
   task automatic wr(input logic [6:0] a, input logic [7:0] x, input logic [7:0] d);
      i_i2c_host_model.write_reg(a, x, d);
   endtask : wr
   // ---
   // Result monitor and watchdog
   // ---
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      rom_n <= rom_n + int'(rom_p === 1'b1);
      log_n <= log_n + int'(log_p === 1'b1);
      if (rd_valid === 1'b1) begin
         check(rd_byte, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hEE);
      end
      if (cyc == 90000) begin
         failures++;
         finish_test();
      end
   end
   // ---
   // Main sequence
   // ---
   initial begin
      repeat (10) @(posedge mclk);
      seed = xs(seed);
      sys_rst <= 1'b0;
      addr_strap <= {1'b1, seed[5:0]};
      repeat (5) @(posedge mclk);
      pd_pin <= 1'b1;
      repeat (8) @(posedge mclk);
      sa = addr_strap;
      na = sa ^ 7'h15;
      rd(sa, 8'h00, {sa, 1'b0});
      rd(sa, 8'h01, 8'h00);
      rd(sa, 8'h02, 8'h33);
      check({7'h00, sda_out}, 8'h00);
      rd(sa, 8'h03, 8'h4B);
      rd(sa, 8'h10, 8'h00);
      wr(sa, 8'h00, {na, 1'b0});
      rd(sa, 8'h00, {sa, 1'b0});
      wr(sa, 8'h00, {na, 1'b1});
      rd(na, 8'h00, {na, 1'b1});
      rd(sa, 8'h00, 8'hFF);
      check({1'b0, bus_addr}, {1'b0, na});
      seed = xs(seed);
      cfg = seed[7:0];
      wr(na, 8'h02, cfg);
      i_i2c_host_model.half = 12;
      rd(na, 8'h02, cfg);
      i_i2c_host_model.half = 4;
      check({3'h0, clk_on, lanes, crc_en, v18}, {3'h0, cfg[6], cfg[5:4], cfg[1:0]});
      wr(na, 8'h03, 8'h05);
      rd(na, 8'h03, 8'h4B);
      foreach (modes[k]) begin
         wr(na, 8'h03, {5'h02, modes[k]});
         rd(na, 8'h03, {5'h0B, modes[k]});
         check({5'h00, mode}, {5'h00, modes[k]});
      end
      wr(na, 8'h01, 8'h04);
      rd(na, 8'h01, 8'h00);
      check(rom_n[7:0], 8'h01);
      wr(na, 8'h01, 8'h01);
      rd(na, 8'h02, cfg);
      check(log_n[7:0], 8'h01);
      wr(na, 8'h01, 8'h02);
      rd(sa, 8'h02, 8'h33);
      check(log_n[7:0], 8'h02);
      rd(sa, 8'h00, {sa, 1'b0});
      check({1'b0, bus_addr}, {1'b0, sa});
      repeat (4) @(posedge mclk);
      check(exp_q.size(), 8'h00);
      finish_test();
   end
endmodule : serializer_core_config_regs_tb_top
